//--- pkg/pxb_pkg.sv
// Package: constants, types and helpers for the port and external memory bus block
package pxb_pkg;

	// ****************************************************************
	// Register map (byte addresses on the register bus)
	// ****************************************************************
	localparam logic [9:0] ADR_LATCH0  = 10'h000;
	localparam logic [9:0] ADR_LATCH1  = 10'h004;
	localparam logic [9:0] ADR_LATCH2  = 10'h008;
	localparam logic [9:0] ADR_LATCH3  = 10'h00C;
	localparam logic [9:0] ADR_PIN0    = 10'h010;
	localparam logic [9:0] ADR_PIN1    = 10'h014;
	localparam logic [9:0] ADR_PIN2    = 10'h018;
	localparam logic [9:0] ADR_PIN3    = 10'h01C;
	localparam logic [9:0] ADR_CTRL    = 10'h020;
	localparam logic [9:0] ADR_STATUS  = 10'h024;
	localparam logic [9:0] ADR_XADDR   = 10'h028;
	localparam logic [9:0] ADR_XDATA   = 10'h02C;
	localparam logic [9:0] ADR_XCMD    = 10'h030;
	localparam logic [9:0] ADR_VERIFY  = 10'h034;
	localparam logic [9:0] ADR_PROGBYT = 10'h038;
	localparam logic [7:0] AUX_IDX     = 8'h8E;
	localparam logic [9:0] ADR_AUX     = {AUX_IDX, 2'b00};

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int         AUX_ALE_DIS = 0;
	localparam int         AUX_RTO_DIS = 3;
	localparam logic [7:0] AUX_RESET   = 8'h00;
	localparam logic [7:0] AUX_WMASK   = 8'h09;
	localparam int         CTL_LOCK1   = 0;
	localparam int         CTL_PROGRAM_PULSE_IN    = 1;
	localparam int         CTL_VERIFY  = 2;
	localparam logic [2:0] CTL_RESET   = 3'h0;
	localparam int         ST_BUSY     = 0;
	localparam int         ST_EXTEXEC  = 1;
	localparam int         ST_PROGSEEN = 2;
	localparam int         ST_DEVRST   = 3;
	localparam int         ST_RTOACT   = 4;
	localparam logic [7:0] PORT_RESET  = 8'hFF;
	localparam logic [7:0] BYTE_ZERO   = 8'h00;
	localparam logic [7:0] BYTE_ONES   = 8'hFF;

	// Alternate function bit positions
	localparam int P1_T2   = 0;
	localparam int P1_TIMER2_TRIGGER_IN = 1;
	localparam int P1_MOSI = 5;
	localparam int P1_MISO = 6;
	localparam int P1_SCK  = 7;
	localparam int P3_RXD  = 0;
	localparam int P3_TXD  = 1;
	localparam int P3_EXT_IRQ_ZERO = 2;
	localparam int P3_EXT_IRQ_ONE = 3;
	localparam int P3_T0   = 4;
	localparam int P3_T1   = 5;

	// ****************************************************************
	// Timing (clk_sys serves as the oscillator)
	// ****************************************************************
	localparam int         CLK_PER_OSC  = 1;
	localparam int         OSC_PER_MC   = 12;
	localparam int         RST_HOLD_MC  = 2;
	localparam int         RST_HOLD_CYC = RST_HOLD_MC * OSC_PER_MC * CLK_PER_OSC;
	localparam int         RST_OUT_OSC  = 98;
	localparam int         RST_OUT_CYC  = RST_OUT_OSC * CLK_PER_OSC;
	localparam int         SYNC_SETTLE  = 3;
	localparam logic [2:0] SUB_ALE_END  = 3'h1;
	localparam logic [2:0] SUB_ADR_END  = 3'h2;
	localparam logic [2:0] SUB_STB_BEG  = 3'h3;
	localparam logic [2:0] SUB_LAST     = 3'h5;
	localparam logic [2:0] SUB_RD_BEG   = 3'h1;
	localparam logic [2:0] SUB_WR_BEG   = 3'h1;
	localparam logic [2:0] SUB_WR_END   = 3'h4;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {CMD_RD16, CMD_WR16, CMD_RD8, CMD_WR8, CMD_CODE} pxb_cmd_e;
	typedef enum logic [1:0] {H_IDLE, H_DADDR, H_DXFER, H_CODE} pxb_half_e;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pu;
	} pxb_pins_s;

	typedef struct packed {
		logic timer2_count_in;
		logic timer2_trigger_in;
		logic spi_mosi;
		logic spi_miso;
		logic spi_sck;
		logic serial_rx;
		logic serial_tx;
		logic ext_irq_zero;
		logic ext_irq_one;
		logic timer0_count_in;
		logic timer1_count_in;
	} pxb_alt_in_s;

	// Quasi-bidirectional drive: strong low for a zero, weak pull-up for a one
	function automatic pxb_pins_s quasi_drive(input logic [7:0] val);
		pxb_pins_s p;
		p.out = BYTE_ZERO;
		p.oe  = ~val;
		p.pu  = val;
		return p;
	endfunction

endpackage

//--- hdl/pxb_port_bus.sv
// Module: port pins, alternate functions, external memory bus and reset pin logic

// Functional notes
// - First port is open drain; a one in its latch releases the pin as input.
// - During external accesses first port carries low address then data, pulled up.
// - Ports two to four are quasi-bidirectional; a one is pulled high and readable.
// - Second port bit 0 is timer2 count/clock out, bit 1 its trigger input.
// - Second port bits 5, 6, 7 carry the programming SPI MOSI, MISO, SCK.
// - Third port drives high address strongly for fetches and 16-bit data accesses.
// - For 8-bit data accesses third port keeps showing its own latch.
// - Fourth port bits carry serial, interrupt, timer and data strobe functions.
// - Reset input held high two machine cycles resets the device.
// - After a watchdog timeout the reset pin is driven high 98 oscillator periods.
// - A disable bit in aux control suppresses that reset drive; default is enabled.
// - Address latch strobe pulses so the external latch captures the low address.
// - Latch strobe runs at one sixth oscillator rate, one pulse skipped per data access.
// - Aux bit 0 limits latch strobes to data and code-table moves, weak high otherwise.
// - The latch strobe disable has no effect during external execution.
// - Program read strobe twice per machine cycle, two skipped per data access.
// - Access select low sends all fetches external; high runs internal code.
// - With lock bit one set, access select comes from a latch loaded in the first three clocks after reset.
// - Programming mode: code bytes on first port, low address on second, strobe as pulse.
module pxb_port_bus (
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	input  wire logic [9:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	output logic      [31:0]         avs_readdata,
	output logic                     avs_waitrequest,
	input  wire logic [7:0]          low_bus_port_in,
	output pxb_pkg::pxb_pins_s       low_bus_port_drv,
	input  wire logic [7:0]          second_port_in,
	output pxb_pkg::pxb_pins_s       second_port_drv,
	input  wire logic [7:0]          high_address_port_in,
	output pxb_pkg::pxb_pins_s       high_address_port_drv,
	input  wire logic [7:0]          fourth_port_in,
	output pxb_pkg::pxb_pins_s       fourth_port_drv,
	input  wire logic [7:0]          second_port_alt_out,
	input  wire logic [5:0]          fourth_port_alt_out,
	output pxb_pkg::pxb_alt_in_s     alt_in,
	input  wire logic                reset_pin_in,
	output logic                     reset_pin_out,
	output logic                     reset_pin_oe,
	output logic                     device_reset,
	input  wire logic                wdt_timeout,
	input  wire logic                ale_in,
	output logic                     ale_out,
	output logic                     ale_oe,
	output logic                     ale_pullup_en,
	output logic                     program_read_strobe_n,
	input  wire logic                external_access_select_in
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	localparam int          SYNC_W    = 35;
	localparam logic [34:0] SYNC_INIT = 35'h7FFFFFFFF;
	localparam logic [4:0]  HOLD_MAX  = 5'(pxb_pkg::RST_HOLD_CYC);
	localparam logic [6:0]  RTO_LOAD  = 7'(pxb_pkg::RST_OUT_CYC);
	localparam logic [1:0]  SETTLE    = 2'(pxb_pkg::SYNC_SETTLE);

	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [SYNC_W-1:0] sync3_reg;
	logic [SYNC_W-1:0] filt_reg;
	wire  [SYNC_W-1:0] sync_in;
	wire  [SYNC_W-1:0] agree;
	wire  [SYNC_W-1:0] filt_next;

	assign sync_in   = {external_access_select_in, reset_pin_in, ale_in, fourth_port_in,
		high_address_port_in, second_port_in, low_bus_port_in};
	// A change counts once the second and third stages agree
	assign agree     = ~(sync2_reg ^ sync3_reg);
	assign filt_next = (sync3_reg & agree) | (filt_reg & ~agree);

	// Three stage pipeline plus agreement filter
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync1_reg <= SYNC_INIT;
			sync2_reg <= SYNC_INIT;
			sync3_reg <= SYNC_INIT;
			filt_reg  <= SYNC_INIT;
		end else begin
			sync1_reg <= sync_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			filt_reg  <= filt_next;
		end
	end

	wire [7:0] pin0  = filt_reg[7:0];
	wire [7:0] pin1  = filt_reg[15:8];
	wire [7:0] pin2  = filt_reg[23:16];
	wire [7:0] pin3  = filt_reg[31:24];
	wire       ale_f = filt_reg[32];
	wire       rst_f = filt_reg[33];
	wire       ea_f  = filt_reg[34];

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [7:0]         latch0_reg;
	logic [7:0]         latch1_reg;
	logic [7:0]         latch2_reg;
	logic [7:0]         latch3_reg;
	logic [7:0]         aux_reg;
	logic [2:0]         ctrl_reg;
	logic [15:0]        xaddr_reg;
	logic [7:0]         xwdata_reg;
	logic [7:0]         xrdata_reg;
	logic [7:0]         verify_reg;
	logic [7:0]         program_pulse_in_byte_reg;
	logic               program_pulse_in_seen_reg;
	pxb_pkg::pxb_cmd_e  cmd_reg;
	logic               pend_reg;
	logic               rd_ack_reg;
	logic [31:0]        rdata_reg;
	logic [2:0]         cap_reg;

	wire program_pulse_in_mode = ctrl_reg[pxb_pkg::CTL_PROGRAM_PULSE_IN];
	wire verify_on = ctrl_reg[pxb_pkg::CTL_VERIFY];

	// ****************************************************************
	// Bus engine state
	// ****************************************************************
	pxb_pkg::pxb_half_e half_reg;
	pxb_pkg::pxb_half_e half_next;
	logic [2:0]         sub_reg;
	logic               phase_hi_reg;
	logic [15:0]        fetch_pc_reg;
	logic               ea_lat_reg;
	logic [1:0]         ea_cnt_reg;

	wire busy = pend_reg | (half_reg != pxb_pkg::H_IDLE) | (cap_reg != 3'h0);

	// ****************************************************************
	// Register bus decode
	// ****************************************************************
	wire sel_l0   = avs_address == pxb_pkg::ADR_LATCH0;
	wire sel_l1   = avs_address == pxb_pkg::ADR_LATCH1;
	wire sel_l2   = avs_address == pxb_pkg::ADR_LATCH2;
	wire sel_l3   = avs_address == pxb_pkg::ADR_LATCH3;
	wire sel_ctrl = avs_address == pxb_pkg::ADR_CTRL;
	wire sel_stat = avs_address == pxb_pkg::ADR_STATUS;
	wire sel_xadr = avs_address == pxb_pkg::ADR_XADDR;
	wire sel_xdat = avs_address == pxb_pkg::ADR_XDATA;
	wire sel_xcmd = avs_address == pxb_pkg::ADR_XCMD;
	wire sel_ver  = avs_address == pxb_pkg::ADR_VERIFY;
	wire sel_aux  = avs_address == pxb_pkg::ADR_AUX;

	// Command writes stall while a transfer runs, so software never loses one
	assign avs_waitrequest = (avs_read & ~rd_ack_reg) | (avs_write & sel_xcmd & busy);
	wire wr_en   = avs_write & ~avs_waitrequest;
	wire cmd_ok  = avs_writedata[2:0] <= pxb_pkg::CMD_CODE;
	wire cmd_go  = wr_en & sel_xcmd & cmd_ok;
	wire seen_clr = wr_en & sel_stat & avs_writedata[pxb_pkg::ST_PROGSEEN];

	logic       dev_rst_reg;
	logic       rto_act_reg;
	wire        ext_exec;

	wire [7:0] status_byte = {3'h0, rto_act_reg, dev_rst_reg, program_pulse_in_seen_reg, ext_exec, busy};

	// Read selection; unmapped addresses read as zero
	wire [7:0] rd_byte =
		sel_l0   ? latch0_reg :
		sel_l1   ? latch1_reg :
		sel_l2   ? latch2_reg :
		sel_l3   ? latch3_reg :
		(avs_address == pxb_pkg::ADR_PIN0) ? pin0 :
		(avs_address == pxb_pkg::ADR_PIN1) ? pin1 :
		(avs_address == pxb_pkg::ADR_PIN2) ? pin2 :
		(avs_address == pxb_pkg::ADR_PIN3) ? pin3 :
		sel_ctrl ? {5'h00, ctrl_reg} :
		sel_stat ? status_byte :
		sel_xdat ? xrdata_reg :
		sel_xcmd ? {5'h00, cmd_reg} :
		sel_ver  ? verify_reg :
		(avs_address == pxb_pkg::ADR_PROGBYT) ? program_pulse_in_byte_reg :
		sel_aux  ? aux_reg : pxb_pkg::BYTE_ZERO;
	wire [31:0] rd_word = sel_xadr ? {16'h0000, xaddr_reg} : {24'h000000, rd_byte};

	// Read answer: one wait cycle, data from a register
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rd_ack_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
		end else begin
			rd_ack_reg <= avs_read & ~rd_ack_reg;
			if (avs_read & ~rd_ack_reg) begin
				rdata_reg <= rd_word;
			end
		end
	end
	assign avs_readdata = rdata_reg;

	// Software-written registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			latch0_reg <= pxb_pkg::PORT_RESET;
			latch1_reg <= pxb_pkg::PORT_RESET;
			latch2_reg <= pxb_pkg::PORT_RESET;
			latch3_reg <= pxb_pkg::PORT_RESET;
			aux_reg    <= pxb_pkg::AUX_RESET;
			ctrl_reg   <= pxb_pkg::CTL_RESET;
			xaddr_reg  <= 16'h0000;
			xwdata_reg <= pxb_pkg::BYTE_ZERO;
			verify_reg <= pxb_pkg::BYTE_ZERO;
		end else if (wr_en) begin
			if (sel_l0) latch0_reg <= avs_writedata[7:0];
			if (sel_l1) latch1_reg <= avs_writedata[7:0];
			if (sel_l2) latch2_reg <= avs_writedata[7:0];
			if (sel_l3) latch3_reg <= avs_writedata[7:0];
			if (sel_aux) aux_reg <= avs_writedata[7:0] & pxb_pkg::AUX_WMASK;
			if (sel_ctrl) ctrl_reg <= avs_writedata[2:0];
			if (sel_xadr) xaddr_reg <= avs_writedata[15:0];
			if (sel_xdat) xwdata_reg <= avs_writedata[7:0];
			if (sel_ver) verify_reg <= avs_writedata[7:0];
		end
	end

	// ****************************************************************
	// Access select latch
	// ****************************************************************
	// Capture samples the filter output for three clocks after reset release, then holds
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ea_cnt_reg <= 2'h0;
			ea_lat_reg <= 1'b1;
		end else if (ea_cnt_reg != SETTLE) begin
			ea_cnt_reg <= ea_cnt_reg + 2'h1;
			ea_lat_reg <= ea_f;
		end
	end
	wire ea_eff = ctrl_reg[pxb_pkg::CTL_LOCK1] ? ea_lat_reg : ea_f;
	assign ext_exec = ~ea_eff;

	// ****************************************************************
	// Machine cycle sequencer
	// ****************************************************************
	wire half_end = sub_reg == pxb_pkg::SUB_LAST;
	// Data moves start only in a second half so their strobe half opens a cycle
	wire accept   = half_end & pend_reg & ~phase_hi_reg & ~program_pulse_in_mode;
	wire is16     = (cmd_reg == pxb_pkg::CMD_RD16) | (cmd_reg == pxb_pkg::CMD_WR16);
	wire iswr     = (cmd_reg == pxb_pkg::CMD_WR16) | (cmd_reg == pxb_pkg::CMD_WR8);
	wire st_idle  = half_reg == pxb_pkg::H_IDLE;
	wire st_daddr = half_reg == pxb_pkg::H_DADDR;
	wire st_dxfer = half_reg == pxb_pkg::H_DXFER;
	wire st_code  = half_reg == pxb_pkg::H_CODE;
	wire fetch_h  = st_idle & ext_exec & ~program_pulse_in_mode;

	assign half_next = ~half_end ? half_reg :
		st_daddr ? pxb_pkg::H_DXFER :
		~accept ? pxb_pkg::H_IDLE :
		(cmd_reg == pxb_pkg::CMD_CODE) ? pxb_pkg::H_CODE : pxb_pkg::H_DADDR;

	// Six-clock halves, two per twelve-clock machine cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sub_reg      <= 3'h0;
			phase_hi_reg <= 1'b0;
			half_reg     <= pxb_pkg::H_IDLE;
		end else begin
			sub_reg      <= half_end ? 3'h0 : sub_reg + 3'h1;
			phase_hi_reg <= phase_hi_reg ^ half_end;
			half_reg     <= half_next;
		end
	end

	// Command queue, fetch counter and read capture
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pend_reg     <= 1'b0;
			cmd_reg      <= pxb_pkg::CMD_RD16;
			fetch_pc_reg <= 16'h0000;
			xrdata_reg   <= pxb_pkg::BYTE_ZERO;
			cap_reg      <= 3'h0;
		end else begin
			// Pin filter lags four clocks, so the byte is taken three clocks late
			cap_reg <= {cap_reg[1:0], half_end & ((st_dxfer & ~iswr) | st_code)};
			if (cmd_go) begin
				pend_reg <= 1'b1;
				cmd_reg  <= pxb_pkg::pxb_cmd_e'(avs_writedata[2:0]);
			end else if (accept) begin
				pend_reg <= 1'b0;
			end
			if (half_end & fetch_h) begin
				fetch_pc_reg <= fetch_pc_reg + 16'h0001;
			end
			if (cap_reg[2]) begin
				xrdata_reg <= pin0;
			end
		end
	end

	// ****************************************************************
	// Strobe and pin drive decisions
	// ****************************************************************
	wire ale_win  = sub_reg <= pxb_pkg::SUB_ALE_END;
	wire adr_win  = sub_reg <= pxb_pkg::SUB_ADR_END;
	wire stb_win  = sub_reg >= pxb_pkg::SUB_STB_BEG;
	wire ale_dis  = aux_reg[pxb_pkg::AUX_ALE_DIS];
	// Disable bit is ignored while code runs from outside
	wire ale_mode = ~program_pulse_in_mode & (~ale_dis | ext_exec | ~st_idle);
	// The strobe half of a data move carries no pulse, so one is skipped
	wire ale_puls = ale_mode & ale_win & (st_idle | st_daddr | st_code);
	// Address and data halves skip the two program read strobes
	wire program_read_strobe_on  = ~program_pulse_in_mode & stb_win & (fetch_h | st_code);

	wire bus_on   = ~program_pulse_in_mode & (fetch_h | st_daddr | st_dxfer | st_code);
	wire p0_adr   = ~program_pulse_in_mode & adr_win & (fetch_h | st_daddr | st_code);
	wire p0_wdat  = ~program_pulse_in_mode & st_dxfer & iswr;
	wire [15:0] bus_adr = fetch_h ? fetch_pc_reg : xaddr_reg;
	wire p2_adr   = ~program_pulse_in_mode & (fetch_h | st_code | ((st_daddr | st_dxfer) & is16));

	wire rd_n = ~(~program_pulse_in_mode & st_dxfer & ~iswr & (sub_reg >= pxb_pkg::SUB_RD_BEG));
	wire wr_n = ~(~program_pulse_in_mode & st_dxfer & iswr & (sub_reg >= pxb_pkg::SUB_WR_BEG)
		& (sub_reg <= pxb_pkg::SUB_WR_END));

	pxb_pkg::pxb_pins_s p0_next;
	pxb_pkg::pxb_pins_s p1_next;
	pxb_pkg::pxb_pins_s p2_next;
	pxb_pkg::pxb_pins_s p3_next;

	// First port: address, write data, verify byte, or open-drain latch
	assign p0_next.out = p0_adr ? bus_adr[7:0] :
		p0_wdat ? xwdata_reg :
		(program_pulse_in_mode & verify_on) ? verify_reg : pxb_pkg::BYTE_ZERO;
	assign p0_next.oe  = program_pulse_in_mode ? {8{verify_on}} :
		(p0_adr | p0_wdat) ? pxb_pkg::BYTE_ONES :
		bus_on ? pxb_pkg::BYTE_ZERO : ~latch0_reg;
	assign p0_next.pu  = bus_on ? pxb_pkg::BYTE_ONES : pxb_pkg::BYTE_ZERO;

	// Second port: latch gated by peripheral outputs, released in programming
	assign p1_next = pxb_pkg::quasi_drive(program_pulse_in_mode ? pxb_pkg::BYTE_ONES :
		latch1_reg & second_port_alt_out);

	// Third port: strong address drive or its own latch
	assign p2_next.out = p2_adr ? bus_adr[15:8] : pxb_pkg::BYTE_ZERO;
	assign p2_next.oe  = p2_adr ? pxb_pkg::BYTE_ONES : ~latch2_reg;
	assign p2_next.pu  = p2_adr ? pxb_pkg::BYTE_ZERO : latch2_reg;

	// Fourth port: top two bits are the data strobes
	assign p3_next = pxb_pkg::quasi_drive(latch3_reg
		& {rd_n, wr_n, fourth_port_alt_out});

	// Registered pin drives; costs one clock of skew on every pin alike
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			low_bus_port_drv      <= pxb_pkg::quasi_drive(pxb_pkg::BYTE_ONES);
			second_port_drv       <= pxb_pkg::quasi_drive(pxb_pkg::BYTE_ONES);
			high_address_port_drv <= pxb_pkg::quasi_drive(pxb_pkg::BYTE_ONES);
			fourth_port_drv       <= pxb_pkg::quasi_drive(pxb_pkg::BYTE_ONES);
			ale_out               <= 1'b0;
			ale_oe                <= 1'b0;
			ale_pullup_en         <= 1'b1;
			program_read_strobe_n <= 1'b1;
		end else begin
			low_bus_port_drv      <= p0_next;
			second_port_drv       <= p1_next;
			high_address_port_drv <= p2_next;
			fourth_port_drv       <= p3_next;
			ale_out               <= ale_puls;
			ale_oe                <= ale_mode;
			ale_pullup_en         <= ~ale_mode & ~program_pulse_in_mode;
			program_read_strobe_n <= ~program_read_strobe_on;
		end
	end

	// Alternate inputs go to the other peripherals from filtered pins
	assign alt_in.timer2_count_in   = pin1[pxb_pkg::P1_T2];
	assign alt_in.timer2_trigger_in = pin1[pxb_pkg::P1_TIMER2_TRIGGER_IN];
	assign alt_in.spi_mosi          = pin1[pxb_pkg::P1_MOSI];
	assign alt_in.spi_miso          = pin1[pxb_pkg::P1_MISO];
	assign alt_in.spi_sck           = pin1[pxb_pkg::P1_SCK];
	assign alt_in.serial_rx         = pin3[pxb_pkg::P3_RXD];
	assign alt_in.serial_tx         = pin3[pxb_pkg::P3_TXD];
	assign alt_in.ext_irq_zero      = pin3[pxb_pkg::P3_EXT_IRQ_ZERO];
	assign alt_in.ext_irq_one       = pin3[pxb_pkg::P3_EXT_IRQ_ONE];
	assign alt_in.timer0_count_in   = pin3[pxb_pkg::P3_T0];
	assign alt_in.timer1_count_in   = pin3[pxb_pkg::P3_T1];

	// ****************************************************************
	// Programming pulse capture
	// ****************************************************************
	logic ale_prev_reg;
	wire  program_pulse_in_fall = program_pulse_in_mode & ale_prev_reg & ~ale_f;

	// Sticky flag: a new pulse in the clearing cycle still sets it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ale_prev_reg  <= 1'b1;
			program_pulse_in_seen_reg <= 1'b0;
			program_pulse_in_byte_reg <= pxb_pkg::BYTE_ZERO;
		end else begin
			ale_prev_reg  <= ale_f;
			program_pulse_in_seen_reg <= program_pulse_in_fall | (program_pulse_in_seen_reg & ~seen_clr);
			if (program_pulse_in_fall) begin
				program_pulse_in_byte_reg <= pin0;
			end
		end
	end

	// ****************************************************************
	// Reset pin: input qualification and watchdog drive
	// ****************************************************************
	logic [4:0] hold_cnt_reg;
	logic [6:0] rto_cnt_reg;
	wire  [6:0] rto_cnt_next = (wdt_timeout & ~aux_reg[pxb_pkg::AUX_RTO_DIS]
		& ~rto_act_reg) ? RTO_LOAD :
		(rto_cnt_reg != 7'h00) ? rto_cnt_reg - 7'h01 : 7'h00;

	// High must last two full machine cycles before the device resets
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			hold_cnt_reg <= 5'h00;
			dev_rst_reg  <= 1'b0;
			rto_cnt_reg  <= 7'h00;
			rto_act_reg  <= 1'b0;
		end else begin
			hold_cnt_reg <= ~rst_f ? 5'h00 :
				(hold_cnt_reg == HOLD_MAX) ? HOLD_MAX : hold_cnt_reg + 5'h01;
			dev_rst_reg  <= rst_f & (hold_cnt_reg == HOLD_MAX);
			rto_cnt_reg  <= rto_cnt_next;
			rto_act_reg  <= rto_cnt_next != 7'h00;
		end
	end

	assign reset_pin_out = rto_act_reg;
	assign reset_pin_oe  = rto_act_reg;
	assign device_reset  = dev_rst_reg;

endmodule

//--- test/pxb_port_bus_monitor.sv
// Checker on the port and memory bus pins
module pxb_port_bus_monitor (
	input wire logic			clk_sys,
	input wire logic			sys_rst,
	input wire pxb_pkg::pxb_pins_s	second_port_drv,
	input wire pxb_pkg::pxb_pins_s	fourth_port_drv,
	input wire logic			reset_pin_in,
	input wire logic			reset_pin_out,
	input wire logic			reset_pin_oe,
	input wire logic			device_reset,
	input wire logic			ale_out,
	input wire logic			ale_oe,
	input wire logic			program_read_strobe_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [7:0] rto_cnt_reg;
	// Length of the current reset-out drive
	always_ff @(posedge clk_sys) begin
		rto_cnt_reg <= (sys_rst || !reset_pin_oe) ? 8'h00 : rto_cnt_reg + 8'h01;
	end
	ale_width_a: assert property ($rose(ale_out) |=> ale_out ##1 !ale_out)
		else $error("latch strobe width");
	ale_gap_a: assert property ($rose(ale_out) |=> (!$rose(ale_out)) [*5])
		else $error("latch strobes too close");
	ale_drive_a: assert property (ale_out |-> ale_oe) else $error("strobe undriven");
	program_read_strobe_width_a: assert property ($fell(program_read_strobe_n) |->
		(!program_read_strobe_n) [*3] ##1 program_read_strobe_n) else $error("read strobe width");
	rto_len_a: assert property ($fell(reset_pin_oe) |-> rto_cnt_reg == 8'h62)
		else $error("reset-out length");
	rto_level_a: assert property (reset_pin_oe |-> reset_pin_out) else $error("reset-out low");
	quasi_high_a: assert property (((second_port_drv.oe & second_port_drv.out) |
		(fourth_port_drv.oe & fourth_port_drv.out)) == 8'h00) else $error("strong high");
	dev_rst_a: assert property ($rose(device_reset) |-> $past(reset_pin_in, 24))
		else $error("reset too early");
	cover property ($fell(reset_pin_oe));
	cover property (fourth_port_drv.oe[6]);
	cover property ($rose(device_reset));
endmodule
bind pxb_port_bus pxb_port_bus_monitor i_pxb_port_bus_monitor (.*);

//--- test/pxb_ext_mem.sv
// External memory with its address latch
module pxb_ext_mem (
	input wire logic		ale_out,
	input wire logic		program_read_strobe_n,
	input wire logic [7:0]	fourth_port_in,
	input wire logic [7:0]	low_bus_port_in,
	output logic [7:0]		dq,
	output logic			dq_oe
);
	logic [7:0] lat_reg;
	logic [7:0] mem [256];
	// Low address taken as the strobe falls, byte still on the bus
	always @(negedge ale_out) lat_reg = low_bus_port_in;
	// Write data taken as the strobe falls; data already stands a clock before
	always @(negedge fourth_port_in[6]) mem[lat_reg] = low_bus_port_in;
	// Drive only under a read strobe; pull-ups hold the bus otherwise
	assign dq_oe = !program_read_strobe_n || !fourth_port_in[7];
	assign dq = mem[lat_reg];
endmodule

//--- test/pxb_port_bus_tb_top.sv
// Bench for the port and external memory bus block
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
	$display("BAD %0t got %h exp %h", $time, a, b); end end
module pxb_port_bus_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest, wdt_timeout;
	logic external_access_select_in, reset_pin_out, reset_pin_oe, device_reset;
	logic ale_out, ale_oe, ale_pullup_en, program_read_strobe_n, dq_oe;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [7:0] dq, hi;
	pxb_pkg::pxb_pins_s low_bus_port_drv, second_port_drv, high_address_port_drv, fourth_port_drv;
	pxb_pkg::pxb_alt_in_s alt_in;
	int miscompares, checks, cyc, ales, pse;
	function automatic logic [7:0] pin(input pxb_pkg::pxb_pins_s d, input logic [7:0] x);
		return (d.oe & d.out) | (~d.oe & x);
	endfunction
	// Pin levels from every driver, pull-ups elsewhere
	wire [7:0] low_bus_port_in = pin(low_bus_port_drv, dq_oe ? dq : 8'hFF);
	wire [7:0] second_port_in = pin(second_port_drv, 8'hFF);
	wire [7:0] high_address_port_in = pin(high_address_port_drv, 8'hFF);
	wire [7:0] fourth_port_in = pin(fourth_port_drv, 8'hFF);
	wire reset_pin_in = reset_pin_oe & reset_pin_out;
	wire [7:0] second_port_alt_out = 8'hFF;
	wire [5:0] fourth_port_alt_out = 6'h3F;
	wire ale_in = 1'b1;
	pxb_port_bus i_pxb_port_bus (.*);
	pxb_ext_mem i_pxb_ext_mem (.*);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge ale_out) ales++;
	always @(negedge program_read_strobe_n) pse++;
	// High byte seen while a strobe is active
	always @(posedge clk_sys) begin
		if (!program_read_strobe_n || fourth_port_drv.oe[7:6] != 2'b00) hi <= high_address_port_in;
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		if (miscompares == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// One register bus cycle, held until the wait ends
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic xfer(input logic [31:0] k, input logic [31:0] a, input logic [31:0] d);
		bus(1, pxb_pkg::ADR_XADDR, a);
		bus(1, pxb_pkg::ADR_XDATA, d);
		bus(1, pxb_pkg::ADR_XCMD, k);
		do bus(0, pxb_pkg::ADR_STATUS, 0); while (q[pxb_pkg::ST_BUSY] !== 1'b0);
		bus(0, pxb_pkg::ADR_XDATA, 0);
	endtask
	initial begin
		{sys_rst, external_access_select_in} = 2'b11;
		{avs_read, avs_write, wdt_timeout, avs_address, avs_writedata} = '0;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		bus(0, pxb_pkg::ADR_AUX, 0);
		`CHK(q, 32'h00)
		bus(1, pxb_pkg::ADR_AUX, 32'hFF);
		bus(0, pxb_pkg::ADR_AUX, 0);
		`CHK(q, 32'h09)
		bus(0, 10'h3FC, 0);
		`CHK(q, 32'h00)
		// Strobe off and reset-out suppressed
		wdt_timeout <= 1'b1;
		@(posedge clk_sys);
		wdt_timeout <= 1'b0;
		ales = 0;
		repeat (120) @(posedge clk_sys);
		`CHK(reset_pin_oe, 1'b0)
		`CHK({ale_oe, ale_pullup_en}, 2'b01)
		xfer(1, 32'h1234, 32'hA5);
		`CHK(hi, 8'h12)
		xfer(0, 32'h1234, 0);
		`CHK(q[7:0], 8'hA5)
		xfer(3, 32'h0056, 32'h3C);
		`CHK(hi, 8'hFF)
		xfer(2, 32'h0056, 0);
		`CHK(q[7:0], 8'h3C)
		xfer(4, 32'h1234, 0);
		`CHK(q[7:0], 8'hA5)
		`CHK(ales, 5)
		for (int i = 0; i < 4; i++) begin
			bus(1, 10'(4 * i), 32'hC5 + i);
			repeat (10) @(posedge clk_sys);
			bus(0, 10'(16 + 4 * i), 0);
			`CHK(q, 32'hC5 + i)
		end
		// External execution overrides the strobe disable
		external_access_select_in <= 1'b0;
		repeat (12) @(posedge clk_sys);
		{ales, pse} = '0;
		repeat (120) @(posedge clk_sys);
		`CHK(ales, 20)
		`CHK(pse, 20)
		bus(1, pxb_pkg::ADR_AUX, 0);
		wdt_timeout <= 1'b1;
		@(posedge clk_sys);
		wdt_timeout <= 1'b0;
		repeat (60) @(posedge clk_sys);
		`CHK(device_reset, 1'b1)
		print_verdict();
	end
endmodule
